/* pkg/ppirq_pkg.sv */
// Package: constants, types and register layout of the parallel port and interrupt block
package ppirq_pkg;

   // ----------------------------------------------------------------
   // Register offsets in the port's I/O window
   // ----------------------------------------------------------------
   localparam logic [1:0] PPIRQ_OFS_DATA = 2'h0;    // Data out (write) / data in (read)
   localparam logic [1:0] PPIRQ_OFS_STATUS = 2'h1;  // Port status, read only
   localparam logic [1:0] PPIRQ_OFS_CONTROL = 2'h2; // Port control
   localparam logic [1:0] PPIRQ_OFS_MODECFG = 2'h3; // Mode configuration

   // ----------------------------------------------------------------
   // Values after reset
   // ----------------------------------------------------------------
   localparam logic [7:0] PPIRQ_DOUT_RST = 8'h00;    // Data output register
   localparam logic [7:0] PPIRQ_PINDATA_RST = 8'hFF; // Data pins idle high
   localparam logic [5:0] PPIRQ_CONTROL_RST = 6'h00; // Low six control bits
   localparam logic [1:0] PPIRQ_CONTROL_TOP = 2'h3;  // Bits 7:6 always read one
   localparam logic [7:0] PPIRQ_DIN_RST = 8'hFF;     // Latched input byte

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int PPIRQ_CTL_DIR = 5;     // Data direction input
   localparam int PPIRQ_CTL_IRQEN = 4;   // Port interrupt enable
   localparam int PPIRQ_CTL_SELIN = 3;   // Select-in asserted when set
   localparam int PPIRQ_CTL_INIT = 2;    // Init pin level
   localparam int PPIRQ_CTL_AUTOFD = 1;  // Auto-feed asserted when set
   localparam int PPIRQ_CTL_STROBE = 0;  // Strobe asserted when set
   localparam int PPIRQ_CFG_ECPINT = 4;  // ECP error interrupt flag
   localparam int PPIRQ_CFG_SPACE = 3;   // EPP address space select
   localparam int PPIRQ_CFG_EPP = 2;     // EPP mode enable
   localparam int PPIRQ_CFG_ECPREV = 1;  // ECP reverse direction
   localparam int PPIRQ_CFG_ECP = 0;     // ECP mode enable
   localparam int PPIRQ_SUM_PORT = 7;    // Summary bit of the parallel port
   localparam int PPIRQ_UARTS = 2;       // UART channels merged

   // ----------------------------------------------------------------
   // Buffer shape
   // ----------------------------------------------------------------
   localparam int PPIRQ_FIFO_DEPTH = 16; // Reverse bytes buffered
   localparam int PPIRQ_FIFO_WIDTH = 9;  // Command flag plus byte

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      PPIRQ_MODE_SPP = 2'b00,
      PPIRQ_MODE_EPP = 2'b01,
      PPIRQ_MODE_ECP = 2'b11
   } ppirq_mode_t;

   typedef enum logic [1:0] {
      PPIRQ_HS_IDLE = 2'b00,
      PPIRQ_HS_STROBE = 2'b01,
      PPIRQ_HS_RELEASE = 2'b11,
      PPIRQ_HS_END = 2'b10
   } ppirq_hs_t;

   typedef struct packed {
      logic busy;
      logic ack;
      logic paper_end;
      logic select;
      logic error;
   } ppirq_status_t;

   typedef struct packed {
      logic [3:0] src;     // Raw pending sources of the channel
      logic [3:0] enable;  // Channel interrupt enable register
      logic out_gate;      // Output gate bit of modem control
   } ppirq_uart_t;

   typedef struct packed {
      logic command;
      logic [7:0] data;
   } ppirq_word_t;

endpackage

/* hw/ppirq_sync.sv */
// Three-stage pin synchroniser that passes a change once stages two and three agree
`timescale 1ns/100ps
`default_nettype none
module ppirq_sync #(
   parameter int W = 13,
   parameter logic [12:0] RST_VAL = 13'h1FFF
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [W-1:0] raw,
   output var logic [W-1:0] stable
);
   // ----------------------------------------------------------------
   // One chain per bit
   // ----------------------------------------------------------------
   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         logic s1_q; // First stage, read only by the second
         logic s2_q;
         logic s3_q;
         // Shift and accept agreed level
         always_ff @(posedge clk) begin
            if (rst) begin
               s1_q <= RST_VAL[i];
               s2_q <= RST_VAL[i];
               s3_q <= RST_VAL[i];
               stable[i] <= RST_VAL[i];
            end else begin
               s1_q <= raw[i];
               s2_q <= s1_q;
               s3_q <= s2_q;
               if (s2_q == s3_q) begin
                  stable[i] <= s3_q;
               end
            end
         end
      end
   endgenerate
endmodule
`default_nettype wire

/* hw/ppirq_fifo.sv */
// Synchronous valid/ready FIFO with parameter width and depth
`timescale 1ns/100ps
`default_nettype none
module ppirq_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 16
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH]; // Storage
   logic [AW:0] wr_q;             // Write pointer with wrap bit
   logic [AW:0] rd_q;             // Read pointer with wrap bit
   wire push = in_valid & in_ready;
   wire pop = out_valid & out_ready;

   // Honest full and empty from the pointers
   assign out_valid = (wr_q != rd_q);
   assign in_ready = ~((wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]));
   assign out_data = mem[rd_q[AW-1:0]];

   // Pointer update
   always_ff @(posedge clk) begin
      if (rst) begin
         wr_q <= '0;
         rd_q <= '0;
      end else begin
         if (push) begin
            wr_q <= wr_q + 1'b1;
         end
         if (pop) begin
            rd_q <= rd_q + 1'b1;
         end
      end
   end

   // Storage write
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_q[AW-1:0]] <= in_data;
      end
   end
endmodule
`default_nettype wire

/* hw/ppirq_top.sv */
// Parallel port sequencer in SPP, EPP and ECP modes with merged interrupt output
`timescale 1ns/100ps
`default_nettype none
module ppirq_top
   import ppirq_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic [1:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   input wire ppirq_uart_t [PPIRQ_UARTS-1:0] uart_irq,
   output logic irq_req,
   output logic [7:0] irq_summary,
   input wire logic [7:0] pp_data_in,
   output logic [7:0] pp_data_out,
   output logic pp_data_oe,
   input wire ppirq_status_t pp_status_in,
   output logic pp_strobe,
   output logic pp_autofd,
   output logic pp_init,
   output logic pp_selin
);

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   logic [12:0] pins_s;     // Synchronised status and data pins
   ppirq_status_t stat_s;   // Status pins in core clock
   logic [7:0] din_s;       // Data pins in core clock

   ppirq_sync #(.W(13), .RST_VAL(13'h1FFF)) u_sync (
      .clk(clk),
      .rst(rst),
      .raw({pp_status_in, pp_data_in}),
      .stable(pins_s)
   );
   assign stat_s = ppirq_status_t'(pins_s[12:8]);
   assign din_s = pins_s[7:0];

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   ppirq_mode_t mode_q;        // Port mode
   ppirq_mode_t mode_d;        // Mode from a configuration write
   ppirq_hs_t hs_q;            // Handshake state
   ppirq_hs_t hs_d;
   logic [5:0] ctl_q;          // Control register low bits
   logic space_q;              // EPP address space select
   logic ecp_rev_q;            // ECP reverse direction
   logic [7:0] dout_q;         // Data output register
   logic [7:0] pin_data_q;     // Level driven on data pins
   logic [7:0] epp_in_q;       // Byte latched by an EPP read
   logic spp_flag_n_q;         // Inverted ack interrupt flag
   logic ecp_flag_q;           // ECP error interrupt flag
   logic ack_prev_q;           // Ack level one cycle back
   logic err_prev_q;           // Error level one cycle back
   logic hs_rev_q;             // Running handshake is ECP reverse
   logic [7:0] rdata_q;        // Read answer
   logic [7:0] summary_q;      // Source summary
   logic irq_q;                // Shared request
   logic strobe_q, autofd_q, init_q, selin_q, oe_q;

   // ----------------------------------------------------------------
   // Register decode
   // ----------------------------------------------------------------
   wire wr_data = reg_wr & (reg_addr == PPIRQ_OFS_DATA);
   wire wr_ctl = reg_wr & (reg_addr == PPIRQ_OFS_CONTROL);
   wire wr_cfg = reg_wr & (reg_addr == PPIRQ_OFS_MODECFG);
   wire rd_data = reg_rd & (reg_addr == PPIRQ_OFS_DATA);
   wire rd_status = reg_rd & (reg_addr == PPIRQ_OFS_STATUS);
   wire rd_cfg = reg_rd & (reg_addr == PPIRQ_OFS_MODECFG);
   wire is_spp = (mode_q == PPIRQ_MODE_SPP);
   wire is_epp = (mode_q == PPIRQ_MODE_EPP);
   wire is_ecp = (mode_q == PPIRQ_MODE_ECP);
   wire hs_idle = (hs_q == PPIRQ_HS_IDLE);
   wire hs_strobe = (hs_q == PPIRQ_HS_STROBE);

   // ECP priority when both mode bits are written
   assign mode_d = reg_wdata[PPIRQ_CFG_ECP] ? PPIRQ_MODE_ECP :
                   reg_wdata[PPIRQ_CFG_EPP] ? PPIRQ_MODE_EPP : PPIRQ_MODE_SPP;

   // ----------------------------------------------------------------
   // Reverse buffer
   // ----------------------------------------------------------------
   logic fifo_in_ready;
   logic fifo_out_valid;
   ppirq_word_t fifo_in;
   ppirq_word_t fifo_out;
   logic [PPIRQ_FIFO_WIDTH-1:0] fifo_out_bits;

   // Peripheral clock low with a free slot captures a byte
   wire start_rev = hs_idle & is_ecp & ecp_rev_q & ~stat_s.ack & fifo_in_ready;
   wire fifo_push = start_rev;
   wire fifo_pop = rd_data & is_ecp;
   assign fifo_in.command = ~stat_s.busy;   // Busy low marks a command byte
   assign fifo_in.data = din_s;
   assign fifo_out = ppirq_word_t'(fifo_out_bits);

   ppirq_fifo #(.WIDTH(PPIRQ_FIFO_WIDTH), .DEPTH(PPIRQ_FIFO_DEPTH)) u_fifo (
      .clk(clk),
      .rst(rst),
      .in_valid(fifo_push),
      .in_ready(fifo_in_ready),
      .in_data(fifo_in),
      .out_valid(fifo_out_valid),
      .out_ready(fifo_pop),
      .out_data(fifo_out_bits)
   );

   // ----------------------------------------------------------------
   // Handshake sequencer
   // ----------------------------------------------------------------
   // Data write starts an EPP cycle or an ECP forward transfer
   wire start_fwd = wr_data & hs_idle & (is_epp | (is_ecp & ~ecp_rev_q));
   wire epp_read = is_epp & ctl_q[PPIRQ_CTL_DIR];
   wire epp_latch = hs_strobe & epp_read & stat_s.busy;

   // Next handshake state
   always_comb begin
      hs_d = hs_q;
      case (hs_q)
         PPIRQ_HS_IDLE: begin
            if (start_fwd || start_rev) begin
               hs_d = PPIRQ_HS_STROBE;
            end
         end
         PPIRQ_HS_STROBE: begin
            if (hs_rev_q) begin
               // Wait for peripheral clock to return high
               if (stat_s.ack) begin
                  hs_d = PPIRQ_HS_END;
               end
            end else if (stat_s.busy) begin
               // Peripheral acknowledged the strobe
               hs_d = PPIRQ_HS_RELEASE;
            end
         end
         PPIRQ_HS_RELEASE: begin
            if (!stat_s.busy) begin
               hs_d = PPIRQ_HS_END;
            end
         end
         PPIRQ_HS_END: begin
            hs_d = PPIRQ_HS_IDLE;
         end
         default: begin
            hs_d = PPIRQ_HS_IDLE;
         end
      endcase
   end

   // Handshake state register, a mode write aborts a transfer
   always_ff @(posedge clk) begin
      if (rst || wr_cfg) begin
         hs_q <= PPIRQ_HS_IDLE;
         hs_rev_q <= 1'b0;
      end else begin
         hs_q <= hs_d;
         if (hs_idle) begin
            hs_rev_q <= start_rev;
         end
      end
   end

   // ----------------------------------------------------------------
   // Software registers
   // ----------------------------------------------------------------
   // Control, mode and data output
   always_ff @(posedge clk) begin
      if (rst) begin
         ctl_q <= PPIRQ_CONTROL_RST;
         mode_q <= PPIRQ_MODE_SPP;
         space_q <= 1'b0;
         ecp_rev_q <= 1'b0;
         dout_q <= PPIRQ_DOUT_RST;
         pin_data_q <= PPIRQ_PINDATA_RST;
      end else begin
         if (wr_ctl) begin
            ctl_q <= reg_wdata[5:0];
         end
         if (wr_cfg) begin
            mode_q <= mode_d;
            space_q <= reg_wdata[PPIRQ_CFG_SPACE];
            ecp_rev_q <= reg_wdata[PPIRQ_CFG_ECPREV];
         end
         if (wr_data) begin
            dout_q <= reg_wdata;
            pin_data_q <= reg_wdata;
         end
      end
   end

   // Byte captured during an EPP read cycle
   always_ff @(posedge clk) begin
      if (rst) begin
         epp_in_q <= PPIRQ_DIN_RST;
      end else if (epp_latch) begin
         epp_in_q <= din_s;
      end
   end

   // ----------------------------------------------------------------
   // Interrupt flags, event wins over the read that clears
   // ----------------------------------------------------------------
   wire ack_rise = stat_s.ack & ~ack_prev_q & ~is_ecp;
   wire err_fall = ~stat_s.error & err_prev_q & is_ecp;

   // Flags update whatever the enables, for polled use
   always_ff @(posedge clk) begin
      if (rst) begin
         ack_prev_q <= 1'b1;
         err_prev_q <= 1'b1;
         spp_flag_n_q <= 1'b1;
         ecp_flag_q <= 1'b0;
      end else begin
         ack_prev_q <= stat_s.ack;
         err_prev_q <= stat_s.error;
         if (ack_rise) begin
            spp_flag_n_q <= 1'b0;
         end else if (rd_status) begin
            spp_flag_n_q <= 1'b1;
         end
         if (err_fall) begin
            ecp_flag_q <= 1'b1;
         end else if (rd_cfg) begin
            ecp_flag_q <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // Interrupt merge
   // ----------------------------------------------------------------
   logic [PPIRQ_UARTS-1:0] uart_pend; // Gated request per channel
   genvar c;
   generate
      for (c = 0; c < PPIRQ_UARTS; c++) begin : g_uart
         assign uart_pend[c] = (|(uart_irq[c].src & uart_irq[c].enable))
                               & uart_irq[c].out_gate;
      end
   endgenerate

   // Pending shown through the mode's own flag
   wire port_pend = is_ecp ? ecp_flag_q : ~spp_flag_n_q;
   wire port_req = port_pend & ctl_q[PPIRQ_CTL_IRQEN];
   wire [7:0] summary_d = {port_req, 5'h00, uart_pend};

   // Summary and level request
   always_ff @(posedge clk) begin
      if (rst) begin
         summary_q <= 8'h00;
         irq_q <= 1'b0;
      end else begin
         summary_q <= summary_d;
         irq_q <= |summary_d;
      end
   end

   // ----------------------------------------------------------------
   // Read answers
   // ----------------------------------------------------------------
   wire fwd_idle_n = ~(~hs_idle & ~hs_rev_q & is_ecp);
   wire epp_idle_n = ~(~hs_idle & is_epp);
   wire in_full_n = ~fifo_out_valid;
   wire cmd_n = ~(fifo_out_valid & fifo_out.command);
   wire [2:0] st_low = is_ecp ? {cmd_n, in_full_n, fwd_idle_n} :
                       is_epp ? {spp_flag_n_q, 1'b1, epp_idle_n} : {spp_flag_n_q, 2'b11};
   wire [7:0] status_rd = {~stat_s.busy, stat_s.ack, stat_s.paper_end,
                           stat_s.select, stat_s.error, st_low};
   wire [7:0] data_rd = is_spp ? din_s : (is_epp ? epp_in_q : fifo_out.data);
   wire [7:0] cfg_rd = is_ecp ? {3'h0, ecp_flag_q, 2'h0, ecp_rev_q, 1'b1} :
                       is_epp ? {4'h0, space_q, 1'b1, 2'h0} : 8'h00;
   wire [7:0] rd_mux = (reg_addr == PPIRQ_OFS_DATA) ? data_rd :
                       (reg_addr == PPIRQ_OFS_STATUS) ? status_rd :
                       (reg_addr == PPIRQ_OFS_CONTROL) ? {PPIRQ_CONTROL_TOP, ctl_q} : cfg_rd;

   // Answer held until the next read
   always_ff @(posedge clk) begin
      if (rst) begin
         rdata_q <= 8'h00;
      end else if (reg_rd) begin
         rdata_q <= rd_mux;
      end
   end

   // ----------------------------------------------------------------
   // Pin drive
   // ----------------------------------------------------------------
   wire hs_write = ~hs_idle & ((is_epp & ~epp_read) | (is_ecp & ~hs_rev_q & hs_strobe));
   wire epp_dstb = hs_strobe & is_epp & ~space_q;
   wire epp_astb = hs_strobe & is_epp & space_q;
   wire ecp_rev_mode = is_ecp & ecp_rev_q;
   wire strobe_d = ~(ctl_q[PPIRQ_CTL_STROBE] | hs_write);
   wire autofd_d = ecp_rev_mode ? (hs_strobe & hs_rev_q) :
                   ~(ctl_q[PPIRQ_CTL_AUTOFD] | epp_dstb);
   wire selin_d = ~(ctl_q[PPIRQ_CTL_SELIN] | epp_astb);

   // Output flops, controls idle high and init low
   always_ff @(posedge clk) begin
      if (rst) begin
         strobe_q <= 1'b1;
         autofd_q <= 1'b1;
         selin_q <= 1'b1;
         init_q <= 1'b0;
         oe_q <= 1'b1;
      end else begin
         strobe_q <= strobe_d;
         autofd_q <= autofd_d;
         selin_q <= selin_d;
         init_q <= ctl_q[PPIRQ_CTL_INIT];
         oe_q <= ~ctl_q[PPIRQ_CTL_DIR];
      end
   end

   assign reg_rdata = rdata_q;
   assign irq_req = irq_q;
   assign irq_summary = summary_q;
   assign pp_data_out = pin_data_q;
   assign pp_data_oe = oe_q;
   assign pp_strobe = strobe_q;
   assign pp_autofd = autofd_q;
   assign pp_init = init_q;
   assign pp_selin = selin_q;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking @(posedge clk); endclocking
   default disable iff (rst);

   irq_level_a: assert property (irq_req == $past(port_req | (|uart_pend)))
      else $error("shared request does not follow pending sources");
   port_gate_a: assert property (!ctl_q[PPIRQ_CTL_IRQEN] |=> !irq_summary[PPIRQ_SUM_PORT])
      else $error("port request passed while disabled");
   uart_gate_a: assert property (irq_summary[0] |-> $past(uart_irq[0].out_gate))
      else $error("uart request without output gate");
   ack_edge_a: assert property (ack_rise |=> !spp_flag_n_q)
      else $error("ack rise did not raise flag");
   err_edge_a: assert property (err_fall |=> ##1 irq_summary[PPIRQ_SUM_PORT] == $past(ctl_q[4]))
      else $error("error fall did not reach summary");
   status_clr_a: assert property (rd_status && !ack_rise |=> spp_flag_n_q)
      else $error("status read did not restore flag");
   cfg_clr_a: assert property (rd_cfg && !err_fall |=> !ecp_flag_q)
      else $error("config read did not clear flag");
   epp_busy_a: assert property (start_fwd && is_epp |=> !epp_idle_n)
      else $error("epp cycle flag not low after write");
   rev_full_a: assert property (fifo_push |=> !in_full_n)
      else $error("captured byte not flagged");
   reset_pins_a: assert property ($past(rst) |-> pp_strobe && !pp_init && pp_data_out == 8'hFF)
      else $error("pins wrong after reset");
endmodule
`default_nettype wire

/* bench/ppirq_printer.sv */
// Printer model on the far side of the parallel port
`timescale 1ns/100ps
`default_nettype none
module ppirq_printer
   import ppirq_pkg::*;
(
   input wire logic clk,
   input wire logic [7:0] pp_data_out,
   input wire logic pp_data_oe,
   input wire logic pp_strobe,
   input wire logic pp_autofd,
   input wire logic pp_selin,
   input wire logic ack_in,
   input wire logic err_in,
   input wire logic epp_mode,
   output logic [7:0] pp_data_in,
   output ppirq_status_t status
);
   logic [2:0] dly_q = 3'h0; // Busy answer delay line
   // EPP answers the data or address strobe only, other modes the strobe pin
   wire strobe_seen = epp_mode ? ~(pp_autofd & pp_selin) : ~pp_strobe;
   // Busy rises a few cycles after the strobe and falls after release
   always_ff @(posedge clk) begin
      dly_q <= {dly_q[1:0], strobe_seen};
   end
   // Pin level: port drives when enabled, else our own byte
   assign pp_data_in = pp_data_oe ? pp_data_out : 8'hA5;
   assign status = '{dly_q[2], ack_in, 1'b0, 1'b1, err_in};
endmodule
`default_nettype wire

/* bench/tb.sv */
// Register sequence testbench of the port and interrupt block
`timescale 1ns/100ps
`default_nettype none
module tb;
   import ppirq_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [1:0] reg_addr = 2'h0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [7:0] reg_wdata = 8'h00;
   logic [7:0] reg_rdata, pp_data_out, pp_data_in, irq_summary;
   logic irq_req, pp_data_oe, pp_strobe, pp_autofd, pp_init, pp_selin;
   logic ack_in = 1'b1;
   logic err_in = 1'b1;
   logic epp_mode = 1'b0;
   ppirq_uart_t [PPIRQ_UARTS-1:0] uart_irq = '0;
   ppirq_status_t status;
   int num_errors = 0;
   int checked = 0;
   int cycles = 0;
   always #2 clk = ~clk;
   ppirq_top dut (.clk, .rst, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
      .uart_irq, .irq_req, .irq_summary, .pp_data_in, .pp_data_out, .pp_data_oe,
      .pp_status_in(status), .pp_strobe, .pp_autofd, .pp_init, .pp_selin);
   ppirq_printer peer (.clk, .pp_data_out, .pp_data_oe, .pp_strobe, .pp_autofd,
      .pp_selin, .ack_in, .err_in, .epp_mode, .pp_data_in, .status);
   // Verdict and end of run
   task automatic complete_run();
      $display("errors %0d checks %0d", num_errors, checked);
      if (num_errors == 0 && checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // Compare and count
   task automatic check(input string n, input logic [15:0] s, input logic [15:0] e);
      checked++;
      if (s !== e) begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // One-cycle write strobe, then a spare cycle
   task automatic wr(input logic [1:0] a, input logic [7:0] d);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(posedge clk) #1 reg_wr = 1'b0;
      tick(1);
   endtask
   // One-cycle read strobe, masked compare of the answer
   task automatic rd(input logic [1:0] a, input logic [7:0] m, input logic [7:0] e);
      reg_addr = a;
      reg_rd = 1'b1;
      @(posedge clk) #1 reg_rd = 1'b0;
      check("reg_rdata", reg_rdata & m, e);
      tick(1);
   endtask
   // Cut a hung run short
   always @(posedge clk) begin
      cycles++;
      if (cycles == 2000) begin
         num_errors++;
         complete_run();
      end
   end
   initial begin
      tick(3);
      rst = 1'b0;
      check("data_pins", pp_data_out, 8'hFF);
      check("ctl_pins", {pp_strobe, pp_autofd, pp_init, pp_selin}, 8'h0D);
      rd(2'h2, 8'hFF, 8'hC0);
      rd(2'h3, 8'hFF, 8'h00);
      // Software general I/O in SPP
      wr(2'h2, 8'h0B);
      wr(2'h0, 8'h3C);
      check("ctl_pins", {pp_strobe, pp_autofd, pp_init, pp_selin}, 8'h00);
      tick(6);
      rd(2'h0, 8'hFF, 8'h3C);
      // Ack rise with and without enable
      for (int i = 1; i >= 0; i--) begin
         wr(2'h2, i ? 8'h10 : 8'h00);
         ack_in = 1'b0;
         tick(6);
         ack_in = 1'b1;
         tick(8);
         check("irq", {irq_summary, irq_req}, i ? 9'h101 : 9'h0);
         rd(2'h1, 8'h04, 8'h00);
         rd(2'h1, 8'h04, 8'h04);
         check("irq_req", irq_req, 8'h00);
      end
      // Each UART channel, gated and ungated
      for (int i = 0; i < 2; i++) begin
         uart_irq[i] = '{4'h2, 4'h2, 1'b1};
         tick(3);
         check("uart", {irq_summary, irq_req}, {i ? 8'h02 : 8'h01, 1'b1});
         uart_irq[i].out_gate = 1'b0;
         tick(3);
         check("uart_off", {irq_summary, irq_req}, 9'h0);
         uart_irq[i] = '{4'h2, 4'h1, 1'b1};
         tick(3);
         check("uart_en", {irq_summary, irq_req}, 9'h0);
      end
      // EPP then ECP forward handshake
      for (int i = 0; i < 2; i++) begin
         wr(2'h3, i ? 8'h01 : 8'h04);
         epp_mode = (i == 0);
         wr(2'h0, 8'h5A);
         rd(2'h1, 8'h01, 8'h00);
         tick(30);
         rd(2'h1, 8'h01, 8'h01);
         check("data_pins", pp_data_out, 8'h5A);
      end
      // ECP error fall flag
      err_in = 1'b0;
      tick(8);
      rd(2'h3, 8'h10, 8'h10);
      rd(2'h3, 8'h10, 8'h00);
      // ECP reverse: one command byte captured, then popped
      wr(2'h2, 8'h20);
      wr(2'h3, 8'h03);
      check("data_oe", pp_data_oe, 8'h00);
      ack_in = 1'b0;
      tick(8);
      ack_in = 1'b1;
      tick(8);
      rd(2'h1, 8'h06, 8'h00);
      rd(2'h0, 8'hFF, 8'hA5);
      rd(2'h1, 8'h02, 8'h02);
      // EPP address read cycle latches the peripheral byte
      wr(2'h3, 8'h0C);
      epp_mode = 1'b1;
      wr(2'h0, 8'h00);
      tick(30);
      rd(2'h0, 8'hFF, 8'hA5);
      rd(2'h1, 8'h05, 8'h05);
      complete_run();
   end
endmodule
`default_nettype wire
